// ==== hdl/sdram_access_core.sv ====
`timescale 1ns/1ps
// Functional notes
// RULE1: All inputs are sampled on the rising edge of the one system clock.
// RULE2: Four banks of 4096 rows; 1024, 512 or 256 columns by width.
// RULE3: Two-bit bank select picks one of four banks per bank command.
// RULE4: Controller activates a row before reading or writing that bank.
// RULE5: Activate takes bank select as bank and twelve address bits as row.
// RULE6: Read or write takes its address as the first burst column.
// RULE7: Burst walks consecutive columns in programmed order, generated internally.
// RULE8: Burst length programmable 1, 2, 4 or 8, shared by reads and writes.
// RULE9: Full-page setting supported; terminate command stops a running burst.
// RULE10: Auto precharge closes the row once the burst has finished.
// RULE11: A new column address is accepted on every clock cycle.
// RULE12: One bank may precharge while another bank is being accessed.
// RULE13: Auto refresh mode and power-down mode, both controller driven.
// RULE14: On read or write, address bit ten requests auto precharge.
// RULE15: Precharge with bit ten high closes all banks, else the selected one.
// RULE16: Chip select high masks commands; running bursts still complete.
// RULE17: Full-page burst wraps within the row until interrupted.
module sdram_access_core
  import sdram_access_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Command pins from the controller
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_BITS-1:0] ba,
  input wire logic [ROW_BITS-1:0] addr,
  // Array access beats
  output logic arr_valid,
  output logic arr_write,
  output logic [BANK_BITS-1:0] arr_bank,
  output logic [ROW_BITS-1:0] arr_row,
  output logic [COL_PORT_BITS-1:0] arr_col,
  // Bank and device status
  output logic [BANK_COUNT-1:0] bank_open,
  output logic [BANK_COUNT-1:0] bank_precharging,
  output logic burst_busy,
  output logic refresh_pulse,
  output logic [ROW_BITS-1:0] refresh_row,
  output logic power_down
);

  // Registered pins; the interface is synchronous so one stage suffices
  logic [3:0] cmd_q;
  logic cke_q;
  logic [BANK_BITS-1:0] ba_q;
  logic [ROW_BITS-1:0] addr_q;

  always_ff @(posedge clk_sys or posedge rst) begin // [RULE1]
    if (rst) begin
      cmd_q <= CMD_NOP | 4'h8;
      cke_q <= 1'b0;
      ba_q <= 2'h0;
      addr_q <= 12'h000;
    end else begin
      cmd_q <= {cs_n, ras_n, cas_n, we_n};
      cke_q <= cke;
      ba_q <= ba;
      addr_q <= addr;
    end
  end

  op_state_t state;
  op_state_t next_state;
  logic [2:0] burst_len;
  logic burst_order;

  // Command decode; every valid code has chip select low, so high masks all
  wire cmd_ok = (state == ST_ACTIVE) && cke_q;
  wire is_act = cmd_ok && (cmd_q == CMD_ACTIVATE); // [RULE16]
  wire is_rd = cmd_ok && (cmd_q == CMD_READ);
  wire is_wr = cmd_ok && (cmd_q == CMD_WRITE);
  wire is_pre = cmd_ok && (cmd_q == CMD_PRECHARGE);
  wire is_bst = cmd_ok && (cmd_q == CMD_TERMINATE);
  wire is_ref = cmd_ok && (cmd_q == CMD_REFRESH);
  wire is_lmr = cmd_ok && (cmd_q == CMD_LOAD_MODE);
  wire pre_all = addr_q[AUTOPRE_ADDR_BIT]; // [RULE15]

  // Burst engine state
  logic burst_on;
  logic burst_wr;
  logic burst_ap;
  logic [BANK_BITS-1:0] burst_bank;
  logic [COL_PORT_BITS-1:0] burst_base;
  logic [COL_PORT_BITS-1:0] beat_cnt;
  logic ap_pend;
  logic [BANK_BITS-1:0] ap_bank;
  logic [ROW_BITS-1:0] open_row [BANK_COUNT];

  // Length mask selects the wrap boundary inside the row
  wire full_page = (burst_len == BURST_LEN_PAGE); // [RULE9]
  wire [9:0] len_mask = (burst_len == BURST_LEN_2) ? 10'h001 : // [RULE8]
                        (burst_len == BURST_LEN_4) ? 10'h003 :
                        (burst_len == BURST_LEN_8) ? 10'h007 :
                        full_page ? COL_MASK : 10'h000; // [RULE17]

  // New access replaces any running burst, so a column is taken every cycle
  wire start = is_rd || is_wr; // [RULE11]
  wire stop = is_bst || (is_pre && (pre_all || (ba_q == burst_bank))); // [RULE9]
  wire issue = start || (burst_on && !stop);
  wire [9:0] cur_base = start ? (addr_q[9:0] & COL_MASK) : burst_base; // [RULE6] [RULE14]
  wire [9:0] cur_cnt = start ? 10'h000 : beat_cnt;
  wire [BANK_BITS-1:0] cur_bank = start ? ba_q : burst_bank;
  wire cur_wr = start ? is_wr : burst_wr;
  wire cur_ap = start ? (addr_q[AUTOPRE_ADDR_BIT] && !full_page) : burst_ap; // [RULE14]
  wire use_xor = burst_order && !full_page;
  wire [9:0] low_seq = (cur_base + cur_cnt) & len_mask;
  wire [9:0] low_xor = (cur_base ^ cur_cnt) & len_mask;
  wire [9:0] beat_col = (cur_base & ~len_mask) | (use_xor ? low_xor : low_seq); // [RULE7]
  wire last = !full_page && ((cur_cnt & len_mask) == len_mask);
  wire [9:0] next_cnt = cur_cnt + 10'h001;

  // Mode setting from the load-mode command
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      burst_len <= BURST_LEN_RESET;
      burst_order <= ORDER_RESET;
    end else if (is_lmr) begin
      burst_len <= addr_q[MODE_LEN_LSB +: 3]; // [RULE8]
      burst_order <= addr_q[MODE_ORDER_BIT];
    end
  end

  // Burst progress; chip select does not stop it
  always_ff @(posedge clk_sys or posedge rst) begin // [RULE16]
    if (rst) begin
      burst_on <= 1'b0;
      burst_wr <= 1'b0;
      burst_ap <= 1'b0;
      burst_bank <= 2'h0;
      burst_base <= 10'h000;
      beat_cnt <= 10'h000;
    end else begin
      burst_on <= issue && !last; // [RULE7]
      if (issue) begin
        burst_wr <= cur_wr;
        burst_ap <= cur_ap;
        burst_bank <= cur_bank;
        burst_base <= cur_base;
        beat_cnt <= next_cnt & (full_page ? COL_MASK : 10'h3FF); // [RULE17]
      end
    end
  end

  // Auto precharge starts the cycle after the final beat
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ap_pend <= 1'b0;
      ap_bank <= 2'h0;
    end else begin
      ap_pend <= issue && last && cur_ap; // [RULE10]
      ap_bank <= cur_bank;
    end
  end

  // Per-bank row state; banks are independent so precharge overlaps access
  logic [3:0] rp_cnt [BANK_COUNT];
  for (genvar b = 0; b < BANK_COUNT; b++) begin : g_bank // [RULE2] [RULE3] [RULE12]
    wire act_b = is_act && (ba_q == 2'(b)); // [RULE5]
    wire pre_b = is_pre && (pre_all || (ba_q == 2'(b))); // [RULE15]
    wire ap_b = ap_pend && (ap_bank == 2'(b)); // [RULE10]
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        bank_open[b] <= 1'b0;
        bank_precharging[b] <= 1'b0;
        rp_cnt[b] <= 4'h0;
        open_row[b] <= ROW_RESET;
      end else if (pre_b || ap_b) begin
        bank_open[b] <= 1'b0;
        bank_precharging[b] <= 1'b1;
        rp_cnt[b] <= RP_CYCLES;
      end else if (act_b) begin
        bank_open[b] <= 1'b1;
        open_row[b] <= addr_q; // [RULE5]
      end else if (rp_cnt[b] != 4'h0) begin
        rp_cnt[b] <= rp_cnt[b] - 4'h1;
        bank_precharging[b] <= (rp_cnt[b] != 4'h1);
      end
    end
  end

  // Beat outputs toward the cell array
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arr_valid <= 1'b0;
      arr_write <= 1'b0;
      arr_bank <= 2'h0;
      arr_row <= 12'h000;
      arr_col <= 10'h000;
      burst_busy <= 1'b0;
    end else begin
      arr_valid <= issue;
      arr_write <= cur_wr;
      arr_bank <= cur_bank;
      arr_row <= open_row[cur_bank];
      arr_col <= beat_col; // [RULE7]
      burst_busy <= issue && !last;
    end
  end

  // Refresh walks rows with an internal counter, so no address is needed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      refresh_pulse <= 1'b0;
      refresh_row <= 12'h000;
    end else begin
      refresh_pulse <= is_ref; // [RULE13]
      if (is_ref) begin
        refresh_row <= refresh_row + 12'h001;
      end
    end
  end

  // Power-down only when idle; a low enable mid-burst is not handled here
  always_comb begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (!cke_q && !burst_on) begin
          next_state = ST_POWER_DOWN; // [RULE13]
        end
      end
      ST_POWER_DOWN: begin
        if (cke_q) begin
          next_state = ST_ACTIVE;
        end
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_ACTIVE;
      power_down <= 1'b0;
    end else begin
      state <= next_state;
      power_down <= (next_state == ST_POWER_DOWN);
    end
  end

endmodule : sdram_access_core

// ==== hdl/sdram_access_pkg.sv ====
package sdram_access_pkg;

  // Array geometry
  localparam int BANK_COUNT = 4;
  localparam int BANK_BITS = 2;
  localparam int ROW_BITS = 12;
  localparam int ROWS_PER_BANK = 4096;
  localparam int COL_PORT_BITS = 10;
  localparam int COLS_X4 = 1024;
  localparam int COLS_X8 = 512;
  localparam int COLS_X16 = 256;
  // Organisation built here: the 16-bit wide variant
  localparam logic [9:0] COL_MASK = 10'(COLS_X16 - 1);

  // Commands as {chip select, row strobe, column strobe, write enable}, all active low
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_TERMINATE = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // Address field positions
  localparam int AUTOPRE_ADDR_BIT = 10;
  localparam int MODE_LEN_LSB = 0;
  localparam int MODE_ORDER_BIT = 3;

  // Burst length codes
  localparam logic [2:0] BURST_LEN_1 = 3'h0;
  localparam logic [2:0] BURST_LEN_2 = 3'h1;
  localparam logic [2:0] BURST_LEN_4 = 3'h2;
  localparam logic [2:0] BURST_LEN_8 = 3'h3;
  localparam logic [2:0] BURST_LEN_PAGE = 3'h7;

  // Values after reset
  localparam logic [2:0] BURST_LEN_RESET = BURST_LEN_1;
  localparam logic ORDER_RESET = 1'b0;
  localparam logic [11:0] ROW_RESET = 12'h000;

  // Timing
  localparam int CLK_MHZ = 25;
  localparam int T_RP_NS = 20;
  localparam int RP_RAW = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RP_CYCLES = 4'((RP_RAW < 1) ? 1 : RP_RAW);

  // Device operating state
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b01,
    ST_POWER_DOWN = 2'b10
  } op_state_t;

endpackage : sdram_access_pkg

// ==== verif/sdram_access_props.sv ====
`timescale 1ns/1ps
module sdram_access_props
  import sdram_access_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_BITS-1:0] ba,
  input wire logic [ROW_BITS-1:0] addr,
  // Observed outputs
  input wire logic arr_valid,
  input wire logic arr_write,
  input wire logic [BANK_BITS-1:0] arr_bank,
  input wire logic [COL_PORT_BITS-1:0] arr_col,
  input wire logic [BANK_COUNT-1:0] bank_open,
  input wire logic burst_busy,
  input wire logic refresh_pulse,
  input wire logic power_down
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic cke_q;
  // Decode counts only with clock enable seen on two edges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) cke_q <= 1'b0;
    else cke_q <= cke;
  end
  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire logic live = cke && cke_q && !power_down;

  read_first_beat_a: assert property (live && cmd == CMD_READ |-> ##2 arr_valid
    && !arr_write && arr_col == (COL_MASK & $past(addr[9:0], 2)) && arr_bank == $past(ba, 2))
    else $error("read beat wrong");
  write_first_beat_a: assert property (live && cmd == CMD_WRITE |-> ##2 arr_valid
    && arr_write && arr_bank == $past(ba, 2)) else $error("write beat wrong");
  activate_opens_a: assert property (live && cmd == CMD_ACTIVATE |-> ##2
    bank_open[$past(ba, 2)]) else $error("bank not opened");
  precharge_all_a: assert property (live && cmd == CMD_PRECHARGE && addr[10] |-> ##2
    bank_open == 4'h0) else $error("banks left open");
  precharge_one_a: assert property (live && cmd == CMD_PRECHARGE && !addr[10] |-> ##2
    !bank_open[$past(ba, 2)]) else $error("bank left open");
  refresh_seen_a: assert property (live && cmd == CMD_REFRESH |-> ##2 refresh_pulse)
    else $error("no refresh pulse");
  masked_quiet_a: assert property (cs_n ##1 !burst_busy |=> !arr_valid)
    else $error("masked command acted");
  masked_runs_a: assert property (burst_busy && $past(cs_n) |=> arr_valid)
    else $error("burst cut while masked");
  // A running burst with no new access must stay on its bank and direction
  busy_beat_a: assert property (burst_busy && $past(cs_n) |=> arr_valid
    && arr_bank == $past(arr_bank) && arr_write == $past(arr_write))
    else $error("burst left its bank");
endmodule : sdram_access_props
bind sdram_access_core sdram_access_props i_sdram_access_props (.*);

// ==== verif/sdram_ctrl_model.sv ====
`timescale 1ns/1ps
module sdram_ctrl_model
  import sdram_access_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [BANK_BITS-1:0] ba,
  output logic [ROW_BITS-1:0] addr
);
  // Deselected with clock enabled from time zero
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 2'h0;
    addr = 12'h000;
  end
  // Pins move only just after a rising edge
  task automatic issue(input logic [3:0] k, input logic [1:0] b, input logic [11:0] a);
    @(posedge clk_sys);
    {cs_n, ras_n, cas_n, we_n} <= k;
    ba <= b;
    addr <= a;
  endtask : issue
  // Deselect; stale lines inverted so no one leans on old values
  task automatic idle();
    @(posedge clk_sys);
    cs_n <= 1'b1;
    ba <= ~ba;
    addr <= ~addr;
  endtask : idle
  // Clock enable keeps the same edge discipline as the command pins
  task automatic set_cke(input logic e);
    @(posedge clk_sys);
    cke <= e;
  endtask : set_cke
endmodule : sdram_ctrl_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  import sdram_access_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, arr_valid, arr_write, burst_busy, refresh_pulse, power_down;
  logic [1:0] ba, arr_bank;
  logic [11:0] addr, arr_row, refresh_row;
  logic [9:0] arr_col;
  logic [3:0] bank_open, bank_precharging;
  int err_total = 0;
  int num_checks = 0;
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  sdram_ctrl_model i_sdram_ctrl_model (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
  sdram_access_core i_sdram_access_core (.clk_sys(clk_sys), .rst(rst), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .arr_valid(arr_valid),
    .arr_write(arr_write), .arr_bank(arr_bank), .arr_row(arr_row), .arr_col(arr_col),
    .bank_open(bank_open), .bank_precharging(bank_precharging), .burst_busy(burst_busy),
    .refresh_pulse(refresh_pulse), .refresh_row(refresh_row), .power_down(power_down));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic [3:0] k, input logic [1:0] b, input logic [11:0] a);
    i_sdram_ctrl_model.issue(k, b, a);
  endtask : op
  task automatic rest();
    i_sdram_ctrl_model.idle();
  endtask : rest
  // One beat of a burst, then on to the next edge
  task automatic beat(input logic w, input logic [1:0] b, input logic [11:0] r,
    input logic [9:0] c);
    #1;
    chk({arr_valid, arr_write, arr_bank, arr_row, arr_col}, {1'b1, w, b, r, c});
    @(posedge clk_sys);
  endtask : beat
  task automatic s_read4();
    op(CMD_ACTIVATE, 2'h2, 12'hABC);
    rest();
    @(posedge clk_sys);
    #1;
    chk(bank_open, 4'h4);
    op(CMD_LOAD_MODE, 2'h0, 12'h002);
    op(CMD_READ, 2'h2, 12'h005);
    rest();
    @(posedge clk_sys);
    beat(0, 2'h2, 12'hABC, 10'h005);
    beat(0, 2'h2, 12'hABC, 10'h006);
    beat(0, 2'h2, 12'hABC, 10'h007);
    beat(0, 2'h2, 12'hABC, 10'h004);
  endtask : s_read4
  // Interleaved write with auto close of the row
  task automatic s_write_ap();
    op(CMD_LOAD_MODE, 2'h0, 12'h00A);
    op(CMD_WRITE, 2'h2, 12'h405);
    rest();
    @(posedge clk_sys);
    beat(1, 2'h2, 12'hABC, 10'h005);
    beat(1, 2'h2, 12'hABC, 10'h004);
    beat(1, 2'h2, 12'hABC, 10'h007);
    beat(1, 2'h2, 12'hABC, 10'h006);
    #1;
    chk({bank_open, bank_precharging}, 8'h04);
  endtask : s_write_ap
  // Second read replaces the first at once
  task automatic s_b2b();
    op(CMD_ACTIVATE, 2'h1, 12'h123);
    op(CMD_LOAD_MODE, 2'h0, 12'h001);
    op(CMD_READ, 2'h1, 12'h008);
    op(CMD_READ, 2'h1, 12'h011);
    rest();
    beat(0, 2'h1, 12'h123, 10'h008);
    beat(0, 2'h1, 12'h123, 10'h011);
    beat(0, 2'h1, 12'h123, 10'h010);
  endtask : s_b2b
  task automatic s_mask();
    op(CMD_READ, 2'h1, 12'h00C);
    op(4'hB, 2'h3, 12'h777);
    rest();
    beat(0, 2'h1, 12'h123, 10'h00C);
    beat(0, 2'h1, 12'h123, 10'h00D);
    #1;
    chk(bank_open, 4'h2);
  endtask : s_mask
  // Page burst wraps past the row end, then is stopped
  task automatic s_page();
    op(CMD_LOAD_MODE, 2'h0, 12'h007);
    op(CMD_READ, 2'h1, 12'h0FF);
    op(CMD_NOP, 2'h0, 12'h000);
    op(CMD_TERMINATE, 2'h0, 12'h000);
    rest();
    beat(0, 2'h1, 12'h123, 10'h000);
    #1;
    chk({arr_valid, burst_busy}, 2'h0);
  endtask : s_page
  task automatic s_pre_ref();
    op(CMD_ACTIVATE, 2'h0, 12'h055);
    op(CMD_PRECHARGE, 2'h1, 12'h000);
    op(CMD_PRECHARGE, 2'h0, 12'h400);
    op(CMD_REFRESH, 2'h0, 12'h000);
    rest();
    #1;
    chk(bank_open, 4'h0);
    @(posedge clk_sys);
    #1;
    chk({refresh_pulse, refresh_row}, 13'h1001);
  endtask : s_pre_ref
  // Enable low puts the idle device to sleep; commands are ignored there
  task automatic s_power();
    i_sdram_ctrl_model.set_cke(1'b0);
    op(CMD_ACTIVATE, 2'h3, 12'h0AA);
    rest();
    @(posedge clk_sys);
    #1;
    chk({power_down, bank_open}, 5'h10);
    i_sdram_ctrl_model.set_cke(1'b1);
    op(CMD_ACTIVATE, 2'h3, 12'h0AA);
    rest();
    @(posedge clk_sys);
    #1;
    chk({power_down, bank_open}, 5'h08);
  endtask : s_power
  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    s_read4();
    s_write_ap();
    s_b2b();
    s_mask();
    s_page();
    s_pre_ref();
    s_power();
    summarize();
  end
  // Watchdog far beyond the fifty or so cycles needed
  initial begin
    #20000;
    err_total++;
    summarize();
  end
endmodule : tb
